// [tb_top.sv]
// Testbench: limit registers, comparator and event alert, fault queue.
// Assumes the host model above and the limit alarm top module.
`timescale 1ns/1ps
module tb_top;
	import twl_pkg::*;
	logic clk, rst, temp_valid, reg_wr, reg_rd;
	logic [12:0] temp_value;
	logic [2:0] reg_sel;
	logic [15:0] reg_wdata, reg_rdata, d;
	logic alert_out, alert_oe, critical_alarm_output, critical_alarm_oe;
	logic alert_active, crit_active;
	int n_errors = 0;
	int compares = 0;
	logic [2:0] sels [7] = '{3'h2, 3'h4, 3'h5, 3'h3, 3'h1, 3'h7, 3'h6};
	logic [15:0] rsts [7] = '{16'h0100, 16'h0500, 16'h2000, 16'h2800,
		16'h0000, TWL_MAKER_ID, 16'h0000};

	twl_limit_alarm twl_limit_alarm_inst (.clk(clk), .rst(rst),
		.temp_valid(temp_valid), .temp_value(temp_value),
		.reg_sel(reg_sel), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .alert_out(alert_out),
		.alert_oe(alert_oe), .critical_alarm_output(critical_alarm_output),
		.critical_alarm_oe(critical_alarm_oe),
		.alert_active(alert_active), .crit_active(crit_active));
	twl_host_model twl_host_model_inst (.clk(clk), .reg_sel(reg_sel),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk1(input logic got, input logic exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// A result is compared on the evaluation after it is stored
	task automatic conv2(input logic [12:0] v);
		repeat (2) begin
			@(posedge clk);
			temp_valid <= 1'b1;
			temp_value <= v;
			@(posedge clk);
			temp_valid <= 1'b0;
		end
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask

	task automatic conclude();
		if (n_errors == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		#100us;
		n_errors++;
		conclude();
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		rst = 1'b1;
		temp_valid = 1'b0;
		temp_value = 13'h0000;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			twl_host_model_inst.rd(sels[i], d);
			chk16(d, rsts[i]);
		end
		chk1(alert_oe, 1'b0);
		twl_host_model_inst.wr(3'h7, 16'hFFFF);
		twl_host_model_inst.rd(3'h7, d);
		chk16(d, TWL_MAKER_ID);
		twl_host_model_inst.wr(3'h5, 16'h2207);
		twl_host_model_inst.rd(3'h5, d);
		chk16(d, 16'h2200);
		twl_host_model_inst.wr(3'h5, 16'h2000);
		// Comparator style, high side with hysteresis
		conv2(13'h0410);
		chk1(alert_active, 1'b1);
		chk1(alert_oe, 1'b1);
		chk1(alert_out, 1'b0);
		twl_host_model_inst.rd(3'h0, d);
		chk16(d, 16'h2082);
		conv2(13'h03F0);
		chk1(alert_active, 1'b1);
		conv2(13'h03D0);
		chk1(alert_active, 1'b0);
		conv2(13'h0410);
		twl_host_model_inst.wr(3'h5, 16'h2200);
		settle();
		chk1(alert_oe, 1'b0);
		twl_host_model_inst.wr(3'h5, 16'h2000);
		settle();
		chk1(alert_active, 1'b1);
		conv2(13'h0300);
		// Low side
		conv2(13'h0090);
		chk1(alert_active, 1'b1);
		twl_host_model_inst.rd(3'h0, d);
		chk16(d, 16'h0481);
		conv2(13'h00B0);
		chk1(alert_active, 1'b1);
		conv2(13'h0100);
		chk1(alert_active, 1'b0);
		// Critical
		conv2(13'h0510);
		chk1(crit_active, 1'b1);
		chk1(critical_alarm_oe, 1'b1);
		twl_host_model_inst.rd(3'h0, d);
		chk16(d, 16'h2886);
		conv2(13'h0300);
		chk1(critical_alarm_oe, 1'b0);
		// Event style
		twl_host_model_inst.wr(3'h1, 16'h0002);
		twl_host_model_inst.rd(3'h1, d);
		chk16(d, 16'h0002);
		conv2(13'h0410);
		repeat (20) @(posedge clk);
		#1;
		chk1(alert_active, 1'b1);
		twl_host_model_inst.rd(3'h4, d);
		settle();
		chk1(alert_oe, 1'b0);
		twl_host_model_inst.wr(3'h5, 16'h2200);
		settle();
		chk1(alert_active, 1'b1);
		twl_host_model_inst.rd(3'h0, d);
		settle();
		chk1(alert_active, 1'b0);
		// Fault queue: first pulse still evaluates the old result
		conv2(13'h0300);
		twl_host_model_inst.wr(3'h5, 16'h2000);
		twl_host_model_inst.wr(3'h1, 16'h0010);
		conv2(13'h0410);
		conv2(13'h0410);
		chk1(alert_active, 1'b0);
		conv2(13'h0410);
		chk1(alert_active, 1'b1);
		conv2(13'h0300);
		chk1(alert_active, 1'b0);
		// Active-high polarity, then shutdown keeps flags and gates pins
		twl_host_model_inst.wr(3'h1, 16'h000C);
		settle();
		chk1(alert_oe, 1'b1);
		chk1(critical_alarm_oe, 1'b1);
		conv2(13'h0510);
		chk1(alert_oe, 1'b0);
		chk1(critical_alarm_oe, 1'b0);
		chk1(critical_alarm_output, 1'b0);
		twl_host_model_inst.wr(3'h1, 16'h000D);
		settle();
		chk1(crit_active, 1'b0);
		chk1(alert_active, 1'b0);
		conv2(13'h0300);
		twl_host_model_inst.wr(3'h1, 16'h000C);
		settle();
		chk1(crit_active, 1'b1);
		chk1(alert_active, 1'b1);
		conv2(13'h0300);
		chk1(crit_active, 1'b0);
		chk1(alert_oe, 1'b1);
		conclude();
	end
endmodule

// [twl_cmp_if.sv]
// Interface: one limit comparator and its controller.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface twl_cmp_if;
	logic eval;
	logic [12:0] temp;
	logic [15:0] limit;
	logic [15:0] hyst;
	logic above;
	logic qen;
	logic flag;
	modport ctrl (output eval, temp, limit, hyst, above, qen, input flag);
	modport cmp (input eval, temp, limit, hyst, above, qen, output flag);
endinterface

// [twl_host_model.sv]
// Host model: drives register strobes as the serial front end would.
// Assumes one clock; requests change just after a rising edge.
`timescale 1ns/1ps
module twl_host_model (
	input wire logic clk,
	output logic [2:0] reg_sel,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	output logic reg_rd,
	input wire logic [15:0] reg_rdata
);
	initial begin
		reg_sel = 3'h0;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end

	// ****************************************
	// Register access
	// ****************************************
	// Callers keep hysteresis bands apart and move the window past temp
	task automatic wr(input logic [2:0] s, input logic [15:0] d);
		@(posedge clk);
		reg_sel <= s;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		// Released data must not look valid
		reg_wdata <= ~d;
	endtask

	task automatic rd(input logic [2:0] s, output logic [15:0] d);
		@(posedge clk);
		reg_sel <= s;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
endmodule

// [twl_limit_alarm.sv]
// Module: limit registers, comparisons and alarm outputs of the sensor.
// Assumes the serial bus front end decodes pointer and data into one-cycle
// read and write strobes, and the converter pulses temp_valid per result.
`timescale 1ns/1ps
module twl_limit_alarm
	import twl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic temp_valid,
	input wire logic [12:0] temp_value,
	input wire logic [2:0] reg_sel,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic alert_out,
	output logic alert_oe,
	output logic critical_alarm_output,
	output logic critical_alarm_oe,
	output logic alert_active,
	output logic crit_active
);
	twl_state_s st_reg;
	twl_state_s st_next;
	logic [TWL_NCMP-1:0] flags;
	logic eval;
	logic shdn;
	logic evt_mode;
	logic evt_set;
	logic alert_lvl;
	logic crit_lvl;
	logic [15:0] lim_wdata;
	logic [2:0] status_bits;

	// ********************************************
	// Comparators
	// ********************************************
	twl_cmp_if u_if[TWL_NCMP] ();

	assign shdn = st_reg.cfg[TWL_CFG_SHDN];
	// Limit writes re-run the last result so a moved window acts at once
	assign eval = (temp_valid || st_reg.reeval) && !shdn;

	generate
		for (genvar i = 0; i < TWL_NCMP; i++) begin : g_cmp
			assign u_if[i].eval = eval;
			assign u_if[i].temp = st_reg.temp;
			assign u_if[i].hyst = st_reg.hyst;
			assign u_if[i].qen = st_reg.cfg[TWL_CFG_FQ];
			assign u_if[i].above = (i != TWL_IDX_LOW);
			assign u_if[i].limit = (i == TWL_IDX_HIGH) ? st_reg.high :
				(i == TWL_IDX_LOW) ? st_reg.low : st_reg.crit;
			assign flags[i] = u_if[i].flag;
			twl_trip_cmp u_cmp (
				.clk(clk),
				.rst(rst),
				.c(u_if[i])
			);
		end
	endgenerate

	// ********************************************
	// Registers and alert state
	// ********************************************
	assign evt_mode = st_reg.cfg[TWL_CFG_EVT];
	assign evt_set = (flags[TWL_IDX_HIGH] != st_reg.prev_hi) ||
		(flags[TWL_IDX_LOW] != st_reg.prev_lo);
	// Undefined low bits of a limit are stored as zero
	assign lim_wdata = {reg_wdata[TWL_TMSB:TWL_TLSB], TWL_LOW_ZERO};
	// Status bits in read order: critical, high, low
	assign status_bits = {flags[TWL_IDX_CRIT], flags[TWL_IDX_HIGH],
		flags[TWL_IDX_LOW]};

	always_comb begin
		st_next = st_reg;
		st_next.reeval = 1'b0;
		st_next.prev_hi = flags[TWL_IDX_HIGH];
		st_next.prev_lo = flags[TWL_IDX_LOW];
		if (temp_valid && !shdn) begin
			st_next.temp = temp_value;
		end
		if (reg_wr) begin
			case (reg_sel)
				TWL_SEL_CFG: st_next.cfg = reg_wdata[7:0];
				TWL_SEL_HYST: st_next.hyst = lim_wdata;
				TWL_SEL_CRIT: st_next.crit = lim_wdata;
				TWL_SEL_LOW: st_next.low = lim_wdata;
				TWL_SEL_HIGH: st_next.high = lim_wdata;
				default: st_next.cfg = st_reg.cfg;
			endcase
			st_next.reeval = (reg_sel != TWL_SEL_CFG) && (reg_sel != TWL_SEL_ID) &&
				(reg_sel != TWL_SEL_TEMP);
		end
		if (reg_rd) begin
			st_next.evt = 1'b0;
			case (reg_sel)
				TWL_SEL_TEMP: st_next.rdata = {st_reg.temp, status_bits};
				TWL_SEL_CFG: st_next.rdata = {TWL_CFG_PAD, st_reg.cfg};
				TWL_SEL_HYST: st_next.rdata = st_reg.hyst;
				TWL_SEL_CRIT: st_next.rdata = st_reg.crit;
				TWL_SEL_LOW: st_next.rdata = st_reg.low;
				TWL_SEL_HIGH: st_next.rdata = st_reg.high;
				TWL_SEL_ID: st_next.rdata = TWL_MAKER_ID;
				default: st_next.rdata = TWL_RDATA_NONE;
			endcase
		end
		// A new event beats a read in the same cycle
		if (evt_set && evt_mode) begin
			st_next.evt = 1'b1;
		end
		if (shdn) begin
			st_next.evt = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg.hyst <= TWL_RST_HYST;
			st_reg.low <= TWL_RST_LOW;
			st_reg.high <= TWL_RST_HIGH;
			st_reg.crit <= TWL_RST_CRIT;
			st_reg.cfg <= TWL_RST_CFG;
			st_reg.temp <= '0;
			st_reg.reeval <= 1'b0;
			st_reg.prev_hi <= 1'b0;
			st_reg.prev_lo <= 1'b0;
			st_reg.evt <= 1'b0;
			st_reg.rdata <= TWL_RDATA_NONE;
		end else begin
			st_reg <= st_next;
		end
	end

	// ********************************************
	// Outputs
	// ********************************************
	// Open-drain: only the low level is driven, polarity picks it
	always_comb begin
		alert_active = evt_mode ? st_reg.evt :
			(flags[TWL_IDX_HIGH] || flags[TWL_IDX_LOW]) && !shdn;
		crit_active = flags[TWL_IDX_CRIT] && !shdn;
		alert_lvl = alert_active ? st_reg.cfg[TWL_CFG_APOL] :
			!st_reg.cfg[TWL_CFG_APOL];
		crit_lvl = crit_active ? st_reg.cfg[TWL_CFG_CPOL] :
			!st_reg.cfg[TWL_CFG_CPOL];
	end

	assign reg_rdata = st_reg.rdata;
	assign alert_out = 1'b0;
	assign alert_oe = !alert_lvl;
	assign critical_alarm_output = 1'b0;
	assign critical_alarm_oe = !crit_lvl;

	// ********************************************
	// Checks
	// ********************************************
	a_id_readback: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_sel == TWL_SEL_ID |=> reg_rdata == TWL_MAKER_ID)
		else $error("identification readback wrong");
	a_limit_store: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_sel == TWL_SEL_HIGH |=>
		st_reg.high == $past(lim_wdata))
		else $error("high limit not stored");
	a_low_store: assert property (@(posedge clk) disable iff (rst)
		reg_wr && reg_sel == TWL_SEL_LOW |=>
		st_reg.low[TWL_TLSB-1:0] == TWL_LOW_ZERO)
		else $error("low limit kept undefined bits");
	a_cmp_alert: assert property (@(posedge clk) disable iff (rst)
		!evt_mode && !shdn && (flags[TWL_IDX_HIGH] || flags[TWL_IDX_LOW]) |->
		alert_oe == !st_reg.cfg[TWL_CFG_APOL])
		else $error("comparator alert mismatch");
	a_cmp_idle: assert property (@(posedge clk) disable iff (rst)
		!evt_mode && !flags[TWL_IDX_HIGH] && !flags[TWL_IDX_LOW] |->
		alert_oe == st_reg.cfg[TWL_CFG_APOL])
		else $error("comparator alert active inside window");
	a_crit_apart: assert property (@(posedge clk) disable iff (rst)
		!evt_mode && flags[TWL_IDX_CRIT] && !flags[TWL_IDX_HIGH] &&
		!flags[TWL_IDX_LOW] |-> !alert_active)
		else $error("critical flag drove the alert");
	a_shdn_crit: assert property (@(posedge clk) disable iff (rst)
		shdn |-> !crit_active && critical_alarm_oe == st_reg.cfg[TWL_CFG_CPOL])
		else $error("critical alarm active in shutdown");
	a_evt_pin: assert property (@(posedge clk) disable iff (rst)
		evt_mode && st_reg.evt |-> alert_oe == !st_reg.cfg[TWL_CFG_APOL])
		else $error("event alert not on pin");
	a_evt_mode_only: assert property (@(posedge clk) disable iff (rst)
		!evt_mode && !st_reg.evt |=> !st_reg.evt)
		else $error("event latch set in comparator style");
	a_temp_capture: assert property (@(posedge clk) disable iff (rst)
		temp_valid && !shdn |=> st_reg.temp == $past(temp_value))
		else $error("conversion result not stored");
	a_rd_status: assert property (@(posedge clk) disable iff (rst)
		reg_rd && reg_sel == TWL_SEL_TEMP |=>
		reg_rdata == {$past(st_reg.temp), $past(status_bits)})
		else $error("temperature readback wrong");
	a_evt_hold: assert property (@(posedge clk) disable iff (rst)
		evt_mode && st_reg.evt && !reg_rd && !st_next.cfg[TWL_CFG_SHDN] &&
		!shdn |=> st_reg.evt)
		else $error("event alert dropped without read");
	a_evt_read_clr: assert property (@(posedge clk) disable iff (rst)
		reg_rd && !evt_set && !reg_wr |=> !st_reg.evt)
		else $error("read did not clear event alert");
	a_evt_on_change: assert property (@(posedge clk) disable iff (rst)
		evt_mode && !shdn && evt_set |=> st_reg.evt)
		else $error("flag change gave no event");
	a_crit_pin: assert property (@(posedge clk) disable iff (rst)
		crit_active |-> critical_alarm_oe == !st_reg.cfg[TWL_CFG_CPOL])
		else $error("critical pin level wrong");
endmodule

// [twl_pkg.sv]
// Package: constants and state types for the temperature window limit block.
// Assumes a 13-bit two's complement conversion result, 0.0625 C per LSB.
package twl_pkg;

	// ********************************************
	// Register selection codes
	// ********************************************
	localparam logic [2:0] TWL_SEL_TEMP = 3'h0;
	localparam logic [2:0] TWL_SEL_CFG = 3'h1;
	localparam logic [2:0] TWL_SEL_HYST = 3'h2;
	localparam logic [2:0] TWL_SEL_CRIT = 3'h3;
	localparam logic [2:0] TWL_SEL_LOW = 3'h4;
	localparam logic [2:0] TWL_SEL_HIGH = 3'h5;
	localparam logic [2:0] TWL_SEL_ID = 3'h7;

	// ********************************************
	// Field layout
	// ********************************************
	localparam int TWL_TMSB = 15;
	localparam int TWL_TLSB = 3;
	localparam int TWL_TW = 13;
	localparam int TWL_CW = 15;
	localparam int TWL_CFG_SHDN = 0;
	localparam int TWL_CFG_EVT = 1;
	localparam int TWL_CFG_CPOL = 2;
	localparam int TWL_CFG_APOL = 3;
	localparam int TWL_CFG_FQ = 4;
	localparam logic [2:0] TWL_LOW_ZERO = 3'h0;
	localparam logic [7:0] TWL_CFG_PAD = 8'h00;

	// ********************************************
	// Reset values
	// ********************************************
	localparam logic [15:0] TWL_RST_HYST = 16'h0100;
	localparam logic [15:0] TWL_RST_LOW = 16'h0500;
	localparam logic [15:0] TWL_RST_HIGH = 16'h2000;
	localparam logic [15:0] TWL_RST_CRIT = 16'h2800;
	localparam logic [7:0] TWL_RST_CFG = 8'h00;
	localparam logic [15:0] TWL_RDATA_NONE = 16'h0000;
	// Identification value is arbitrary
	localparam logic [15:0] TWL_MAKER_ID = 16'h5A3C;

	// Consecutive faults before a trip
	localparam logic [1:0] TWL_QUEUE_LAST = 2'h3;
	localparam int TWL_NCMP = 3;
	localparam int TWL_IDX_HIGH = 0;
	localparam int TWL_IDX_LOW = 1;
	localparam int TWL_IDX_CRIT = 2;

	typedef struct packed {
		logic [15:0] hyst;
		logic [15:0] low;
		logic [15:0] high;
		logic [15:0] crit;
		logic [7:0] cfg;
		logic [TWL_TW-1:0] temp;
		logic reeval;
		logic prev_hi;
		logic prev_lo;
		logic evt;
		logic [15:0] rdata;
	} twl_state_s;

	typedef struct packed {
		logic [1:0] cnt;
		logic flag;
	} twl_cmp_s;

endpackage

// [twl_trip_cmp.sv]
// Module: one trip comparator with hysteresis and fault queue.
// Assumes eval is a one-cycle pulse with temp and limits stable.
`timescale 1ns/1ps
module twl_trip_cmp
	import twl_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	twl_cmp_if.cmp c
);
	twl_cmp_s st_reg;
	twl_cmp_s st_next;
	logic signed [TWL_CW-1:0] t_s;
	logic signed [TWL_CW-1:0] l_s;
	logic signed [TWL_CW-1:0] h_s;
	logic signed [TWL_CW-1:0] back_s;
	logic set_c;
	logic clr_c;

	// ********************************************
	// Threshold arithmetic
	// ********************************************
	// Two guard bits keep limit +/- hysteresis from wrapping
	always_comb begin
		t_s = TWL_CW'(signed'(c.temp));
		l_s = TWL_CW'(signed'(c.limit[TWL_TMSB:TWL_TLSB]));
		h_s = TWL_CW'(signed'(c.hyst[TWL_TMSB:TWL_TLSB]));
		back_s = c.above ? (l_s - h_s) : (l_s + h_s);
		set_c = c.above ? (t_s > l_s) : (t_s < l_s);
		clr_c = c.above ? (t_s < back_s) : (t_s > back_s);
	end

	always_comb begin
		st_next = st_reg;
		if (c.eval) begin
			if (set_c) begin
				if (!c.qen || st_reg.cnt == TWL_QUEUE_LAST) begin
					st_next.flag = 1'b1;
				end else begin
					st_next.cnt = st_reg.cnt + 2'h1;
				end
			end else begin
				st_next.cnt = 2'h0;
				if (clr_c) begin
					st_next.flag = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign c.flag = st_reg.flag;

	a_trip_direct: assert property (@(posedge clk) disable iff (rst)
		c.eval && set_c && !c.qen |=> c.flag)
		else $error("flag not set on direct trip");
	a_trip_release: assert property (@(posedge clk) disable iff (rst)
		c.eval && !set_c && clr_c |=> !c.flag)
		else $error("flag not cleared past hysteresis");
	a_queue_four: assert property (@(posedge clk) disable iff (rst)
		$rose(c.flag) |-> !$past(c.qen) || $past(st_reg.cnt) == TWL_QUEUE_LAST)
		else $error("flag set before four faults");
endmodule
